// File: irbm_modulator.sv
// How it works
// - control register at address 03H, option bits
// - writing pulse count starts burst immediately
// - start: output active, load ON-time, count down
// - timer zero in ON: output off, count-1
// - count nonzero: OFF phase, then repeat ON
// - count reaches zero: raise modulator-done interrupt
// - rewriting only count reuses held timings
// - count write or clear bit clears interrupt
// - vectors 03H external, 05H modulator, 07H timer
// - keypad wake-up raises interrupt ending stop
// - enabled: next instruction, then service routine
// - disabled: resume after stop without vectoring
// - any port 1 sense line low wakes
// - test pin ANDed with all port 1
// - watchdog 17 stages clocked at fosc/30
// - reload bit clears watchdog, not stored
// - watchdog starts zero, +1 per 30 cycles
// - watchdog overflow resets whole chip
// - idle mode: watchdog keeps counting
// - stop mode: watchdog holds its count
// - phases last register value plus two
// - continuous bit ignores count, endless pulses
// - long bit: one pulse (ON+2)*count, off ignored
// - carrier bit modulates ON part at fosc/4
`timescale 1ns/100ps
module irbm_modulator
  import irbm_pkg::*;
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // derivative register port from the core
  input  wire irbm_bus_type  bus,
  output logic [7:0]         rdata,
  // pins
  input  wire logic [7:0]    sense_pins,
  input  wire logic          test0_irq_pin,
  output logic               pulse_out_n,
  // core status and interrupt sideband
  input  wire logic          stop_mode,
  input  wire logic          ext_irq_enable,
  output logic               modulator_irq,
  output logic               wakeup_irq,
  output logic               test0_level,
  output logic               ext_vector_take,
  output logic [7:0]         vec_external,
  output logic [7:0]         vec_modulator,
  output logic [7:0]         vec_timer,
  output logic               chip_reset
);
  irbm_state_type cur, next_cur;
  logic [7:0] sense_meta, sense_sync;
  logic       test_meta, test_sync;
  logic       wd_fire;
  logic       count_write, ctrl_write;
  logic       timer_zero;
  // exactly as wide as needed: the longest long pulse, 257 * 1023 cycles, takes all 19 bits
  logic [18:0] long_len;

  // pin inputs cross into the clock domain through two flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sense_meta <= 8'hFF;
      sense_sync <= 8'hFF;
      test_meta  <= 1'b1;
      test_sync  <= 1'b1;
    end else begin
      sense_meta <= sense_pins;
      sense_sync <= sense_meta;
      test_meta  <= test0_irq_pin;
      test_sync  <= test_meta;
    end
  end

  // keypad press on any sense line, or test pin low, wakes the core
  assign test0_level     = test_sync & (&sense_sync);
  assign wakeup_irq      = ~test0_level;
  // the core finishes the instruction after stop before vectoring
  assign ext_vector_take = wakeup_irq & ext_irq_enable;
  assign vec_external    = VEC_EXTERNAL;
  assign vec_modulator   = VEC_MODULATOR;
  assign vec_timer       = VEC_TIMER;

  assign ctrl_write  = bus.wr && bus.addr == ADDR_CONTROL;
  // the low byte completes the count, so only that write starts the burst
  assign count_write = bus.wr && bus.addr == ADDR_COUNT_LO;
  assign timer_zero  = cur.timer == 19'h0;
  assign long_len    = 19'(({11'h0, cur.on_time} + {11'h0, PHASE_EXTRA})
                           * {9'h0, bus.wdata[7:0] == 8'h0 && cur.count_hi == 2'h0
                               ? 10'h1 : {cur.count_hi, bus.wdata}});

  irbm_watchdog u_watchdog (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .reload    (ctrl_write && bus.wdata[BIT_WD_RELOAD]),
    .stop_mode (stop_mode),
    .wd_reset  (wd_fire)
  );

  always_comb begin
    next_cur = cur;
    next_cur.carrier_cnt = cur.carrier_cnt + 2'h1;
    if (bus.wr) begin
      unique case (bus.addr)
        ADDR_ON_TIME:  next_cur.on_time  = bus.wdata;
        ADDR_OFF_TIME: next_cur.off_time = bus.wdata;
        ADDR_COUNT_HI: next_cur.count_hi = bus.wdata[1:0];
        ADDR_CONTROL: begin
          next_cur.ctrl = bus.wdata[BIT_CONTINUOUS:BIT_CARRIER];
        end
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_ON_TIME:  next_cur.rdata = cur.on_time;
        ADDR_OFF_TIME: next_cur.rdata = cur.off_time;
        ADDR_COUNT_LO: next_cur.rdata = cur.remaining[7:0];
        ADDR_CONTROL:  next_cur.rdata = {5'h0, cur.ctrl};
        ADDR_COUNT_HI: next_cur.rdata = {6'h0, cur.remaining[9:8]};
        default:       next_cur.rdata = 8'h0;
      endcase
    end
    // cleared ahead of the sequencer so a done event in the same cycle wins
    if (ctrl_write && bus.wdata[BIT_CLR_IRQ]) begin
      next_cur.done_irq = 1'b0;
    end
    // pulse sequencer; a phase lasts value + 2 cycles
    if (!timer_zero) begin
      next_cur.timer = cur.timer - 19'h1;
    end
    unique case (cur.phase)
      ST_IDLE: begin
        next_cur.pulse_n = 1'b1;
      end
      ST_ON: begin
        if (timer_zero) begin
          next_cur.pulse_n   = 1'b1;
          next_cur.remaining = cur.ctrl[BIT_LONG] ? 10'h0 : cur.remaining - 10'h1;
          if (cur.ctrl[BIT_CONTINUOUS] ||
              (!cur.ctrl[BIT_LONG] && cur.remaining != 10'h1)) begin
            next_cur.phase = ST_OFF;
            next_cur.timer = {11'h0, cur.off_time} + {11'h0, PHASE_EXTRA} - 19'h1;
          end else begin
            next_cur.phase    = ST_IDLE;
            next_cur.done_irq = 1'b1;
          end
        end else begin
          // carrier mode chops the ON part at a quarter of the clock
          next_cur.pulse_n = cur.ctrl[BIT_CARRIER] ? cur.carrier_cnt[1] : 1'b0;
        end
      end
      ST_OFF: begin
        if (timer_zero) begin
          next_cur.phase   = ST_ON;
          next_cur.pulse_n = 1'b0;
          next_cur.timer   = {11'h0, cur.on_time} + {11'h0, PHASE_EXTRA} - 19'h1;
        end
      end
      default: next_cur.phase = ST_IDLE;
    endcase
    // a count write restarts with held timings; a done event in that cycle is
    // dropped on purpose since the write itself clears the flag
    if (count_write) begin
      next_cur.done_irq    = 1'b0;
      next_cur.remaining   = {cur.count_hi, bus.wdata};
      next_cur.phase       = ST_ON;
      next_cur.pulse_n     = 1'b0;
      next_cur.carrier_cnt = 2'h1;
      next_cur.timer       = cur.ctrl[BIT_LONG] ? long_len - 19'h1
                           : {11'h0, cur.on_time} + {11'h0, PHASE_EXTRA} - 19'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur         <= '0;
      cur.phase   <= ST_IDLE;
      cur.ctrl    <= CTRL_RESET;
      cur.pulse_n <= 1'b1;
    end else if (wd_fire) begin
      cur         <= '0;
      cur.phase   <= ST_IDLE;
      cur.pulse_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign pulse_out_n   = cur.pulse_n;
  assign modulator_irq = cur.done_irq;
  assign rdata         = cur.rdata;

  // one-cycle pulse that the chip reset tree widens and applies everywhere
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chip_reset <= 1'b0;
    end else begin
      chip_reset <= wd_fire;
    end
  end
endmodule // irbm_modulator

// File: irbm_pkg.sv
package irbm_pkg;
  // derivative register addresses
  localparam logic [2:0] ADDR_ON_TIME   = 3'h0;
  localparam logic [2:0] ADDR_OFF_TIME  = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LO  = 3'h2;
  localparam logic [2:0] ADDR_CONTROL   = 3'h3;
  localparam logic [2:0] ADDR_COUNT_HI  = 3'h4;
  // control register fields
  localparam int BIT_CARRIER    = 0;
  localparam int BIT_LONG       = 1;
  localparam int BIT_CONTINUOUS = 2;
  localparam int BIT_CLR_IRQ    = 3;
  localparam int BIT_WD_RELOAD  = 4;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // timing
  localparam logic [7:0] PHASE_EXTRA    = 8'h2;
  localparam int         WD_DIV         = 30;
  localparam logic [4:0] WD_DIV_LAST    = 5'(WD_DIV - 1);
  localparam int         WD_STAGES      = 17;
  localparam int         CARRIER_DIV    = 4;
  // interrupt vectors
  localparam logic [7:0] VEC_EXTERNAL  = 8'h03;
  localparam logic [7:0] VEC_MODULATOR = 8'h05;
  localparam logic [7:0] VEC_TIMER     = 8'h07;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } irbm_bus_type;

  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF} irbm_phase_type;

  typedef struct packed {
    logic [7:0]     on_time;
    logic [7:0]     off_time;
    logic [1:0]     count_hi;
    logic [2:0]     ctrl;
    irbm_phase_type phase;
    logic [9:0]     remaining;
    logic [18:0]    timer;
    logic [1:0]     carrier_cnt;
    logic           pulse_n;
    logic           done_irq;
    logic [7:0]     rdata;
  } irbm_state_type;
endpackage

// File: irbm_watchdog.sv
`timescale 1ns/100ps
module irbm_watchdog
  import irbm_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic reload,
  input  wire logic stop_mode,
  // result
  output logic      wd_reset
);
  typedef struct packed {
    logic [4:0]           div;
    logic [WD_STAGES-1:0] count;
    logic                 fire;
  } irbm_wd_type;

  irbm_wd_type cur, next_cur;

  always_comb begin
    next_cur      = cur;
    next_cur.fire = 1'b0;
    if (reload) begin
      next_cur.count = '0;
      next_cur.div   = '0;
    end else if (!stop_mode) begin
      if (cur.div == WD_DIV_LAST) begin
        next_cur.div = '0;
        {next_cur.fire, next_cur.count} = {1'b0, cur.count} + 18'h1;
      end else begin
        next_cur.div = cur.div + 5'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign wd_reset = cur.fire;
endmodule // irbm_watchdog

// File: irbm_checker.sv
`timescale 1ns/100ps
module irbm_checker
  import irbm_pkg::*;
(
  // clock and reset
  input wire logic         sys_clk,
  input wire logic         rst,
  // register port
  input wire irbm_bus_type bus,
  input wire logic [7:0]   rdata,
  // pins and sideband
  input wire logic [7:0]   sense_pins,
  input wire logic         pulse_out_n,
  input wire logic         ext_irq_enable,
  input wire logic         modulator_irq,
  input wire logic         wakeup_irq,
  input wire logic         test0_level,
  input wire logic         ext_vector_take,
  input wire logic         chip_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_start; bus.wr && bus.addr == ADDR_COUNT_LO |=> !pulse_out_n [*2]; endproperty
  a_start: assert property (p_start) else $error("burst start late");
  property p_clr; bus.wr && bus.addr == ADDR_COUNT_LO |=> !modulator_irq; endproperty
  a_clr: assert property (p_clr) else $error("done flag kept");
  property p_and; test0_level != wakeup_irq; endproperty
  a_and: assert property (p_and) else $error("gate mismatch");
  property p_take; ext_vector_take == (wakeup_irq && ext_irq_enable); endproperty
  a_take: assert property (p_take) else $error("vector take wrong");
  // two sync flops in front, so three low samples must show
  property p_wake; (sense_pins != 8'hFF) [*3] |-> wakeup_irq; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_irq; $rose(modulator_irq) |-> pulse_out_n; endproperty
  a_irq: assert property (p_irq) else $error("done while active");
  property p_unmap; bus.rd && bus.addr > ADDR_COUNT_HI |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_nowd; !chip_reset; endproperty
  a_nowd: assert property (p_nowd) else $error("watchdog too early");
  c_done: cover property ($rose(modulator_irq));
  c_wake: cover property ($rose(wakeup_irq));
  c_take: cover property (ext_vector_take);
endmodule // irbm_checker

bind irbm_modulator irbm_checker i_chk (.sys_clk, .rst, .bus, .rdata, .sense_pins,
  .pulse_out_n, .ext_irq_enable, .modulator_irq, .wakeup_irq, .test0_level,
  .ext_vector_take, .chip_reset);

// File: irbm_core_model.sv
`timescale 1ns/100ps
module irbm_core_model
  import irbm_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // derivative register port
  output irbm_bus_type    bus,
  input  wire logic [7:0] rdata
);
  initial bus = '0;
  // one-cycle strobe, then a quiet cycle before the next access
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= {w, !w, a, d};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    acc(1'b0, a, 8'h00);
    #1 d = rdata;
  endtask
  task automatic burst(input logic [7:0] on, input logic [7:0] off, input logic [9:0] cnt);
    acc(1'b1, ADDR_ON_TIME, on);
    acc(1'b1, ADDR_OFF_TIME, off);
    acc(1'b1, ADDR_COUNT_HI, {6'h00, cnt[9:8]});
    acc(1'b1, ADDR_COUNT_LO, cnt[7:0]);
  endtask
endmodule // irbm_core_model

// File: ir_burst_modulator_watchdog_test.sv
`timescale 1ns/100ps
module ir_burst_modulator_watchdog_test
  import irbm_pkg::*;
;
  logic         sys_clk = 0, rst = 1, stop_mode = 0, ext_irq_enable = 0, test0_irq_pin = 1;
  logic [7:0]   sense_pins = 8'hFF, rdata, vx, vm, vt;
  irbm_bus_type bus;
  logic         pulse_out_n, modulator_irq, wakeup_irq, test0_level, ext_vector_take, wd_rst;
  int           num_errors = 0, num_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  irbm_core_model i_core (.sys_clk, .bus, .rdata);
  irbm_modulator i_dut (.sys_clk, .rst, .bus, .rdata, .sense_pins, .test0_irq_pin, .pulse_out_n,
    .stop_mode, .ext_irq_enable, .modulator_irq, .wakeup_irq, .test0_level, .ext_vector_take,
    .vec_external(vx), .vec_modulator(vm), .vec_timer(vt), .chip_reset(wd_rst));
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s: %0h not %0h", $time, what, seen, exp);
    end
  endtask
  task automatic run(input logic lvl, output int n);
    n = 0;
    while (pulse_out_n === lvl && n < 4000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 4000) begin
      chk(n, 0, "timeout");
      give_verdict();
    end
  endtask
  task automatic do_reset();
    @(posedge sys_clk) rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk(pulse_out_n, 1, "idle out");
  endtask
  task automatic pulses(input int on, input int off, input int cnt);
    int n;
    // the first ON phase began on the edge that took the count write
    #1;
    for (int i = 0; i < cnt; i++) begin
      run(1'b0, n);
      chk(n, on + 2, "on len");
      if (i < cnt - 1) run(1'b1, n);
      if (i < cnt - 1) chk(n, off + 2, "off len");
    end
    chk({modulator_irq, pulse_out_n}, 2'b11, "done");
  endtask
  task automatic t_regs();
    logic [7:0] d;
    i_core.acc(1'b1, ADDR_CONTROL, 8'hFF);
    i_core.rd(ADDR_CONTROL, d);
    chk(d, 8'h07, "ctrl read");
    for (int a = 5; a < 8; a++) begin
      i_core.rd(3'(a), d);
      chk(d, 8'h00, "unmapped");
    end
    chk({vx, vm, vt}, 24'h030507, "vectors");
    i_core.acc(1'b1, ADDR_CONTROL, 8'h00);
    $display("regs done");
  endtask
  task automatic t_burst();
    i_core.burst(8'h03, 8'h05, 10'h101);
    pulses(3, 5, 257);
    i_core.acc(1'b1, ADDR_COUNT_HI, 8'h00);
    i_core.acc(1'b1, ADDR_COUNT_LO, 8'h02);
    #1 chk(modulator_irq, 0, "irq kept");
    pulses(3, 5, 2);
    i_core.acc(1'b1, ADDR_CONTROL, 8'h08);
    #1 chk(modulator_irq, 0, "irq kept");
    $display("burst done");
  endtask
  task automatic t_modes();
    int n;
    i_core.acc(1'b1, ADDR_CONTROL, 8'h02);
    i_core.burst(8'h04, 8'h09, 10'h003);
    pulses((4 + 2) * 3 - 2, 0, 1);
    i_core.acc(1'b1, ADDR_CONTROL, 8'h04);
    i_core.acc(1'b1, ADDR_COUNT_LO, 8'h01);
    @(posedge sys_clk);
    #1;
    for (int i = 0; i < 4; i++) begin
      run(1'b0, n);
      run(1'b1, n);
    end
    chk({n[7:0], modulator_irq}, {8'h0B, 1'b0}, "stream");
    do_reset();
    i_core.acc(1'b1, ADDR_CONTROL, 8'h01);
    i_core.burst(8'h06, 8'h00, 10'h001);
    #1 run(1'b0, n);
    chk(n, 2, "carrier");
    $display("modes done");
  endtask
  task automatic t_wake();
    @(posedge sys_clk);
    ext_irq_enable <= 1'b1;
    stop_mode <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      sense_pins <= (i < 8) ? ~(8'h01 << i) : 8'hFF;
      test0_irq_pin <= (i != 8);
      repeat (3) @(posedge sys_clk);
      #1 chk({wakeup_irq, test0_level, ext_vector_take}, (i < 9) ? 5 : 2, "wake");
    end
    ext_irq_enable <= 1'b0;
    stop_mode <= 1'b0;
    chk(wd_rst, 1'b0, "early reset");
    $display("wake done");
  endtask
  initial begin
    do_reset();
    t_regs();
    t_burst();
    t_modes();
    t_wake();
    give_verdict();
  end
endmodule // ir_burst_modulator_watchdog_test
